// ===== hdl/pg_mask_pkg.sv
// constants for the third-output power-good mask bank
// assumes an 8-bit register space behind a two-wire serial target
package pg_mask_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_RAILS = 8'h00AA;
    localparam logic [7:0] OFS_PINS  = 8'h00AB;
    localparam logic [7:0] OFS_CTL   = 8'h00AC;

    // plain defaults; real parts load these from factory configuration
    localparam logic [7:0] RST_RAILS = 8'h00E0;
    localparam logic [7:0] RST_PINS  = 8'h00BF;
    localparam logic [7:0] RST_CTL   = 8'h00AB;
    localparam logic [7:0] UNMAPPED  = 8'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // field positions, rails register
    localparam int RAIL_AUX2_BIT  = 7;
    localparam int RAIL_SWA_BIT   = 6;
    localparam int RAIL_STEP_HI   = 5;
    localparam int RAIL_STEP_LO   = 0;
    localparam int STEP_RAILS     = 6;
    // field positions, pins/aux register
    localparam int PIN_CTL5_BIT   = 7;
    localparam int PIN_CTL4_BIT   = 6;
    localparam int PIN_CTL2_BIT   = 5;
    localparam int PIN_CTL1_BIT   = 4;
    localparam int PIN_VTT_BIT    = 3;
    localparam int PIN_SHARED_BIT = 2;
    localparam int PIN_SWB1_BIT   = 1;
    localparam int PIN_AUX3_BIT   = 0;
    // combined register: pairs for outputs one, four, two, three (high to low)
    localparam int CTL_PAIR_OUT1  = 3;
    localparam int CTL_PAIR_OUT4  = 2;
    localparam int CTL_PAIR_OUT2  = 1;
    localparam int CTL_PAIR_OUT3  = 0;
    localparam int PAIR_P3_OFS    = 1;
    localparam int PAIR_P6_OFS    = 0;
    localparam int PAIR_W         = 2;
    localparam int OTHER_OUTS     = 3;

    // control pin index (pin n at n-1)
    localparam int CTL_PINS = 6;
    localparam int CTL1_IDX = 0;
    localparam int CTL2_IDX = 1;
    localparam int CTL3_IDX = 2;
    localparam int CTL4_IDX = 3;
    localparam int CTL5_IDX = 4;
    localparam int CTL6_IDX = 5;

    ////////////////////////////////////////////////////////////////////////////
    // serial target
    localparam logic [6:0] DEV_ADDR  = 7'h005E;
    localparam logic [3:0] BYTE_BITS = 4'h0008;
    localparam logic [3:0] LAST_BIT  = 4'h0007;
    localparam logic [3:0] CNT_ONE   = 4'h0001;
    localparam logic [7:0] PTR_ONE   = 8'h0001;

    typedef enum logic [8:0] {
        ST_IDLE  = 9'b0_0000_0001,
        ST_ADDR  = 9'b0_0000_0010,
        ST_AACK  = 9'b0_0000_0100,
        ST_REG   = 9'b0_0000_1000,
        ST_RACK  = 9'b0_0001_0000,
        ST_WDAT  = 9'b0_0010_0000,
        ST_WACK  = 9'b0_0100_0000,
        ST_RDAT  = 9'b0_1000_0000,
        ST_MACK  = 9'b1_0000_0000
    } ser_state_t;

endpackage

// ===== hdl/line_events_if.sv
// bus-line events passed from the line sampler to the register target
// assumes one clock domain, events are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface line_events_if;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sdaLevel;

    modport src (output sclRise, output sclFall, output startSeen,
                 output stopSeen, output sdaLevel);
    modport dst (input sclRise, input sclFall, input startSeen,
                 input stopSeen, input sdaLevel);
endinterface
`default_nettype wire

// ===== hdl/line_sampler.sv
// samples the serial clock and data lines and flags edges, start and stop
// assumes lines already synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module line_sampler (
    // clock and reset
    input  wire logic    core_clk,
    input  wire logic    rst_n,
    // bus lines
    input  wire logic    sclIn,
    input  wire logic    sdaIn,
    // events
    line_events_if.src   ev
);
    logic sclNow_r;
    logic sdaNow_r;
    logic sclOld_r;
    logic sdaOld_r;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sclNow_r <= 1'b1;
            sdaNow_r <= 1'b1;
            sclOld_r <= 1'b1;
            sdaOld_r <= 1'b1;
        end
        else
        begin
            sclNow_r <= sclIn;
            sdaNow_r <= sdaIn;
            sclOld_r <= sclNow_r;
            sdaOld_r <= sdaNow_r;
        end
    end

    assign ev.sclRise   = sclNow_r & ~sclOld_r;
    assign ev.sclFall   = ~sclNow_r & sclOld_r;
    assign ev.startSeen = sclNow_r & sclOld_r & sdaOld_r & ~sdaNow_r;
    assign ev.stopSeen  = sclNow_r & sclOld_r & ~sdaOld_r & sdaNow_r;
    assign ev.sdaLevel  = sdaNow_r;
endmodule
`default_nettype wire

// ===== hdl/pg_tree_eval.sv
// one power-good tree: and of every source whose mask bit is clear
// assumes mask 1 means excluded; an all-masked tree reads good
`timescale 1ns/10ps
`default_nettype none
module pg_tree_eval #(
    parameter int WIDTH = 8
) (
    // sources and masks
    input  wire logic [WIDTH-1:0] srcGood,
    input  wire logic [WIDTH-1:0] srcMask,
    // result
    output logic                  treeGood
);
    // a masked source is forced good so its level cannot matter
    assign treeGood = &(srcGood | srcMask);
endmodule
`default_nettype wire

// ===== hdl/power_good_tree_mask_out3.sv
// mask register bank and power-good tree for the third general output
// assumes a two-wire serial host, open-drain data line, core_clk at 20 MHz
`timescale 1ns/10ps
`default_nettype none
module power_good_tree_mask_out3 #(
    parameter logic [6:0] DEV_ADDRESS = pg_mask_pkg::DEV_ADDR,
    parameter logic [7:0] RAILS_INIT  = pg_mask_pkg::RST_RAILS,
    parameter logic [7:0] PINS_INIT   = pg_mask_pkg::RST_PINS,
    parameter logic [7:0] CTL_INIT    = pg_mask_pkg::RST_CTL
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // serial management lines
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // rail power-good inputs, high is good
    input  wire logic [5:0] stepDownPg,
    input  wire logic       loadSwitchAPg,
    input  wire logic       auxLdoTwoPg,
    input  wire logic       auxLdoThreePg,
    input  wire logic       terminationLdoPg,
    input  wire logic       sharedSourcePg,
    input  wire logic       loadSwitchB1Pg,
    // control input pin states, index n-1 for pin n
    input  wire logic [5:0] ctlPin,
    // power-good results
    output logic            thirdGeneralOutputPg,
    output logic [2:0]      otherOutCtlTermGood
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    pg_mask_pkg::ser_state_t state_r;
    pg_mask_pkg::ser_state_t state_nxt;
    logic [3:0] bitCnt_r;
    logic [3:0] bitCnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic       readMode_r;
    logic       readMode_nxt;
    logic       masterNack_r;
    logic       masterNack_nxt;
    logic       sdaOe_r;
    logic       sdaOe_nxt;
    logic       wrStb;

    logic [7:0] railsMask_r;
    logic [7:0] pinsMask_r;
    logic [7:0] ctlMask_r;
    logic       thirdPg_r;
    logic [2:0] otherTerm_r;
    logic       sdaOut_r;

    line_events_if ev ();

    line_sampler u_sampler (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sclIn    (sclIn),
        .sdaIn    (sdaIn),
        .ev       (ev.src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    function automatic logic [7:0] regRead(input logic [7:0] addr,
                                           input logic [7:0] rails,
                                           input logic [7:0] pins,
                                           input logic [7:0] ctl);
        logic [7:0] val;
        val = pg_mask_pkg::UNMAPPED;
        if (addr == pg_mask_pkg::OFS_RAILS)
            val = rails;
        else if (addr == pg_mask_pkg::OFS_PINS)
            val = pins;
        else if (addr == pg_mask_pkg::OFS_CTL)
            val = ctl;
        return val;
    endfunction

    wire [7:0] rdData  = regRead(ptr_r, railsMask_r, pinsMask_r, ctlMask_r);
    wire       wrRails = wrStb & (ptr_r == pg_mask_pkg::OFS_RAILS);
    wire       wrPins  = wrStb & (ptr_r == pg_mask_pkg::OFS_PINS);
    wire       wrCtl   = wrStb & (ptr_r == pg_mask_pkg::OFS_CTL);
    wire       addrHit = (shift_r[7:1] == DEV_ADDRESS);
    wire       byteIn  = (bitCnt_r == pg_mask_pkg::BYTE_BITS);

    ////////////////////////////////////////////////////////////////////////////
    // serial target sequencing

    always_comb
    begin
        state_nxt      = state_r;
        bitCnt_nxt     = bitCnt_r;
        shift_nxt      = shift_r;
        ptr_nxt        = ptr_r;
        readMode_nxt   = readMode_r;
        masterNack_nxt = masterNack_r;
        sdaOe_nxt      = sdaOe_r;
        wrStb          = 1'b0;
        if (ev.stopSeen)
        begin
            state_nxt = pg_mask_pkg::ST_IDLE;
            sdaOe_nxt = 1'b0;
        end
        else if (ev.startSeen)
        begin
            state_nxt  = pg_mask_pkg::ST_ADDR;
            bitCnt_nxt = '0;
            sdaOe_nxt  = 1'b0;
        end
        else if (ev.sclRise)
        begin
            case (state_r)
                pg_mask_pkg::ST_ADDR,
                pg_mask_pkg::ST_REG,
                pg_mask_pkg::ST_WDAT:
                begin
                    shift_nxt  = {shift_r[6:0], ev.sdaLevel};
                    bitCnt_nxt = bitCnt_r + pg_mask_pkg::CNT_ONE;
                end
                pg_mask_pkg::ST_MACK: masterNack_nxt = ev.sdaLevel;
                default: ;
            endcase
        end
        else if (ev.sclFall)
        begin
            case (state_r)
                pg_mask_pkg::ST_ADDR:
                    if (byteIn)
                    begin
                        bitCnt_nxt   = '0;
                        readMode_nxt = shift_r[0];
                        sdaOe_nxt    = addrHit;
                        state_nxt    = addrHit ? pg_mask_pkg::ST_AACK : pg_mask_pkg::ST_IDLE;
                    end
                pg_mask_pkg::ST_REG:
                    if (byteIn)
                    begin
                        bitCnt_nxt = '0;
                        ptr_nxt    = shift_r;
                        sdaOe_nxt  = 1'b1;
                        state_nxt  = pg_mask_pkg::ST_RACK;
                    end
                pg_mask_pkg::ST_WDAT:
                    if (byteIn)
                    begin
                        // write lands now, so the tree sees it on the next edge
                        bitCnt_nxt = '0;
                        wrStb      = 1'b1;
                        sdaOe_nxt  = 1'b1;
                        state_nxt  = pg_mask_pkg::ST_WACK;
                    end
                pg_mask_pkg::ST_AACK:
                    if (readMode_r)
                    begin
                        shift_nxt = rdData;
                        sdaOe_nxt = ~rdData[7];
                        state_nxt = pg_mask_pkg::ST_RDAT;
                    end
                    else
                    begin
                        sdaOe_nxt = 1'b0;
                        state_nxt = pg_mask_pkg::ST_REG;
                    end
                pg_mask_pkg::ST_RACK:
                begin
                    sdaOe_nxt = 1'b0;
                    state_nxt = pg_mask_pkg::ST_WDAT;
                end
                pg_mask_pkg::ST_WACK:
                begin
                    // auto-increment lets one burst fill all three masks
                    sdaOe_nxt = 1'b0;
                    ptr_nxt   = ptr_r + pg_mask_pkg::PTR_ONE;
                    state_nxt = pg_mask_pkg::ST_WDAT;
                end
                pg_mask_pkg::ST_RDAT:
                    if (bitCnt_r == pg_mask_pkg::LAST_BIT)
                    begin
                        bitCnt_nxt = '0;
                        sdaOe_nxt  = 1'b0;
                        ptr_nxt    = ptr_r + pg_mask_pkg::PTR_ONE;
                        state_nxt  = pg_mask_pkg::ST_MACK;
                    end
                    else
                    begin
                        bitCnt_nxt = bitCnt_r + pg_mask_pkg::CNT_ONE;
                        shift_nxt  = {shift_r[6:0], 1'b0};
                        sdaOe_nxt  = ~shift_r[6];
                    end
                pg_mask_pkg::ST_MACK:
                    if (masterNack_r)
                    begin
                        sdaOe_nxt = 1'b0;
                        state_nxt = pg_mask_pkg::ST_IDLE;
                    end
                    else
                    begin
                        shift_nxt = rdData;
                        sdaOe_nxt = ~rdData[7];
                        state_nxt = pg_mask_pkg::ST_RDAT;
                    end
                default:
                begin
                    sdaOe_nxt = 1'b0;
                    state_nxt = pg_mask_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r      <= pg_mask_pkg::ST_IDLE;
            bitCnt_r     <= '0;
            shift_r      <= '0;
            ptr_r        <= '0;
            readMode_r   <= 1'b0;
            masterNack_r <= 1'b0;
            sdaOe_r      <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            bitCnt_r     <= bitCnt_nxt;
            shift_r      <= shift_nxt;
            ptr_r        <= ptr_nxt;
            readMode_r   <= readMode_nxt;
            masterNack_r <= masterNack_nxt;
            sdaOe_r      <= sdaOe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mask registers

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            railsMask_r <= RAILS_INIT;
            pinsMask_r  <= PINS_INIT;
            ctlMask_r   <= CTL_INIT;
        end
        else
        begin
            if (wrRails)
                railsMask_r <= shift_r;
            if (wrPins)
                pinsMask_r <= shift_r;
            if (wrCtl)
                ctlMask_r <= shift_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // third output tree

    localparam int TREE_W = 18;

    wire [TREE_W-1:0] treeSrc;
    wire [TREE_W-1:0] treeMask;
    wire              thirdTree;

    assign treeSrc = {
        auxLdoTwoPg,
        loadSwitchAPg,
        stepDownPg,
        ctlPin[pg_mask_pkg::CTL5_IDX],
        ctlPin[pg_mask_pkg::CTL4_IDX],
        ctlPin[pg_mask_pkg::CTL2_IDX],
        ctlPin[pg_mask_pkg::CTL1_IDX],
        terminationLdoPg,
        sharedSourcePg,
        loadSwitchB1Pg,
        auxLdoThreePg,
        ctlPin[pg_mask_pkg::CTL3_IDX],
        ctlPin[pg_mask_pkg::CTL6_IDX]
    };

    assign treeMask = {
        railsMask_r[pg_mask_pkg::RAIL_AUX2_BIT],
        railsMask_r[pg_mask_pkg::RAIL_SWA_BIT],
        railsMask_r[pg_mask_pkg::RAIL_STEP_HI:pg_mask_pkg::RAIL_STEP_LO],
        pinsMask_r[pg_mask_pkg::PIN_CTL5_BIT],
        pinsMask_r[pg_mask_pkg::PIN_CTL4_BIT],
        pinsMask_r[pg_mask_pkg::PIN_CTL2_BIT],
        pinsMask_r[pg_mask_pkg::PIN_CTL1_BIT],
        pinsMask_r[pg_mask_pkg::PIN_VTT_BIT],
        pinsMask_r[pg_mask_pkg::PIN_SHARED_BIT],
        pinsMask_r[pg_mask_pkg::PIN_SWB1_BIT],
        pinsMask_r[pg_mask_pkg::PIN_AUX3_BIT],
        ctlMask_r[pg_mask_pkg::CTL_PAIR_OUT3 * pg_mask_pkg::PAIR_W
                  + pg_mask_pkg::PAIR_P3_OFS],
        ctlMask_r[pg_mask_pkg::CTL_PAIR_OUT3 * pg_mask_pkg::PAIR_W
                  + pg_mask_pkg::PAIR_P6_OFS]
    };

    pg_tree_eval #(
        .WIDTH (TREE_W)
    ) u_third (
        .srcGood  (treeSrc),
        .srcMask  (treeMask),
        .treeGood (thirdTree)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin three/six terms for outputs one, two and four

    localparam int OTHER_PAIR [pg_mask_pkg::OTHER_OUTS] = '{
        pg_mask_pkg::CTL_PAIR_OUT1,
        pg_mask_pkg::CTL_PAIR_OUT2,
        pg_mask_pkg::CTL_PAIR_OUT4
    };

    wire [pg_mask_pkg::PAIR_W-1:0] pairSrc = {ctlPin[pg_mask_pkg::CTL3_IDX],
                                              ctlPin[pg_mask_pkg::CTL6_IDX]};
    wire [pg_mask_pkg::OTHER_OUTS-1:0] otherTerm;

    genvar g;
    generate
        for (g = 0; g < pg_mask_pkg::OTHER_OUTS; g++)
        begin : g_other
            pg_tree_eval #(
                .WIDTH (pg_mask_pkg::PAIR_W)
            ) u_pair (
                .srcGood  (pairSrc),
                .srcMask  (ctlMask_r[OTHER_PAIR[g] * pg_mask_pkg::PAIR_W
                                     +: pg_mask_pkg::PAIR_W]),
                .treeGood (otherTerm[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // output flops; evaluated every cycle so mask writes apply at once

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            thirdPg_r   <= 1'b0;
            otherTerm_r <= '0;
            sdaOut_r    <= 1'b0;
        end
        else
        begin
            thirdPg_r   <= thirdTree;
            otherTerm_r <= otherTerm;
            sdaOut_r    <= 1'b0;
        end
    end

    assign thirdGeneralOutputPg = thirdPg_r;
    assign otherOutCtlTermGood  = otherTerm_r;
    assign sdaOe                = sdaOe_r;
    // open drain: data low whenever enabled, a tied flop keeps the output registered
    assign sdaOut               = sdaOut_r;

endmodule
`default_nettype wire

// ===== dv/serial_host_model.sv
// serial management host model driving the two-wire lines of the mask bank
// assumes a pulled-up data line; clock rests high between frames
`timescale 1ns/10ps
`default_nettype none
module serial_host_model #(
    parameter logic [6:0] DEV = pg_mask_pkg::DEV_ADDR
) (
    // clock
    input  wire logic core_clk,
    // lines
    input  wire logic sdaIn,
    output logic      sclLine,
    output logic      sdaPull
);
    initial
    begin
        sclLine = 1'b1;
        sdaPull = 1'b0;
    end
    ////////////////////////////////////////
    // four core cycles per quarter, well above the low-phase minimum
    task automatic step(input logic s, input logic d);
        repeat (4) @(posedge core_clk);
        sclLine <= s;
        sdaPull <= d;
    endtask
    task automatic bit_x(input logic tx, output logic rx);
        step(1'b0, ~tx);
        step(1'b1, ~tx);
        repeat (4) @(posedge core_clk);
        rx = sdaIn;
        sclLine <= 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] tx, input logic ackTx, output logic [7:0] rx,
                          output logic ackRx);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(tx[i], b);
            rx = {rx[6:0], b};
        end
        bit_x(ackTx, ackRx);
    endtask
    // also serves as repeated start: data released while clock low
    task automatic start_c();
        step(sclLine, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop_c();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    ////////////////////////////////////////
    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                      output logic nak);
        logic [7:0] r;
        logic       a0, a1, a2;
        start_c();
        byte_x({dev, 1'b0}, 1'b1, r, a0);
        byte_x(ofs, 1'b1, r, a1);
        byte_x(d, 1'b1, r, a2);
        stop_c();
        nak = a0 | a1 | a2;
    endtask
    // two-byte read: master ack on the first byte, nack ends the second
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic [7:0] d2);
        logic [7:0] r;
        logic       a;
        start_c();
        byte_x({DEV, 1'b0}, 1'b1, r, a);
        byte_x(ofs, 1'b1, r, a);
        start_c();
        byte_x({DEV, 1'b1}, 1'b1, r, a);
        byte_x(8'hFF, 1'b0, d, a);
        byte_x(8'hFF, 1'b1, d2, a);
        stop_c();
    endtask
endmodule
`default_nettype wire

// ===== dv/pg_mask_out3_sva.sv
// port-level checker for the third-output mask bank
// assumes the host keeps serial clock low phases of several core cycles
`timescale 1ns/10ps
`default_nettype none
module pg_mask_out3_chk (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // serial lines
    input wire logic       sclIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    // sources
    input wire logic [5:0] stepDownPg,
    input wire logic       loadSwitchAPg,
    input wire logic       auxLdoTwoPg,
    input wire logic       auxLdoThreePg,
    input wire logic       terminationLdoPg,
    input wire logic       sharedSourcePg,
    input wire logic       loadSwitchB1Pg,
    input wire logic [5:0] ctlPin,
    // results
    input wire logic       thirdGeneralOutputPg,
    input wire logic [2:0] otherOutCtlTermGood
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic [17:0] srcAll = {auxLdoTwoPg, loadSwitchAPg, stepDownPg, ctlPin, terminationLdoPg,
                                sharedSourcePg, loadSwitchB1Pg, auxLdoThreePg};
    ////////////////////////////////////////
    a_all_good_high: assert property ((&srcAll)[*3] |-> thirdGeneralOutputPg)
        else $error("tree low with every source good");
    a_pins_good_high: assert property ((ctlPin[2] && ctlPin[5])[*3] |-> &otherOutCtlTermGood)
        else $error("pin terms low with pins three and six good");
    a_quiet_stable: assert property ((sclIn && $stable(srcAll))[*4]
        |-> $stable({thirdGeneralOutputPg, otherOutCtlTermGood}))
        else $error("tree moved with no cause");
    a_sda_high_hold: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
        else $error("data drive changed while clock high");
    a_ack_clock_low: assert property ($rose(sdaOe) |-> !sclIn && !$past(sclIn))
        else $error("data drive rose too near a clock fall");
    a_drive_zero: assert property (sdaOe |-> sdaOut == 1'b0)
        else $error("data line driven high");
    a_drive_release: assert property ($rose(sdaOe) |-> ##[1:300] !sdaOe)
        else $error("data line held low too long");
    a_reset_clear: assert property ($rose(rst_n) |-> !$past(sdaOe)
        && !$past(thirdGeneralOutputPg) && $past(otherOutCtlTermGood) == 3'b000)
        else $error("outputs not cleared in reset");
endmodule
bind power_good_tree_mask_out3 pg_mask_out3_chk u_chk (.core_clk, .rst_n, .sclIn, .sdaOut,
    .sdaOe, .stepDownPg, .loadSwitchAPg, .auxLdoTwoPg, .auxLdoThreePg, .terminationLdoPg,
    .sharedSourcePg, .loadSwitchB1Pg, .ctlPin, .thirdGeneralOutputPg, .otherOutCtlTermGood);
`default_nettype wire

// ===== dv/power_good_tree_mask_out3_bench.sv
// self-checking bench for the third-output mask bank
// assumes the host model and the bound checker are compiled beside it
`timescale 1ns/10ps
`default_nettype none
module power_good_tree_mask_out3_bench;
    logic            core_clk, rst_n, nak;
    logic [5:0]      stepDownPg, ctlPin;
    logic            loadSwitchAPg, auxLdoTwoPg, auxLdoThreePg;
    logic            terminationLdoPg, sharedSourcePg, loadSwitchB1Pg;
    logic [7:0]      rdv, rdv2;
    logic [7:0]      mask [3];
    logic [7:0]      ofsTab [$];
    wire logic       sclLine, sdaPull, sdaOut, sdaOe, third;
    wire logic [2:0] other;
    integer          failures, nTests, seed;
    // pull-up: low when either party pulls
    wire logic       sdaIn = ~(sdaPull | sdaOe);

    power_good_tree_mask_out3 u_power_good_tree_mask_out3 (.core_clk, .rst_n, .sclIn(sclLine),
        .sdaIn, .sdaOut, .sdaOe, .stepDownPg, .loadSwitchAPg, .auxLdoTwoPg, .auxLdoThreePg,
        .terminationLdoPg, .sharedSourcePg, .loadSwitchB1Pg, .ctlPin,
        .thirdGeneralOutputPg(third), .otherOutCtlTermGood(other));
    serial_host_model host (.core_clk, .sdaIn, .sclLine, .sdaPull);

    always #25 core_clk = ~core_clk;
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // drive sources, then compare two clock edges later, one past the output register
    task automatic set_src(input logic [17:0] v);
        logic [17:0] g;
        logic [1:0]  p;
        logic [3:0]  e;
        @(posedge core_clk);
        {stepDownPg, ctlPin, loadSwitchAPg, auxLdoTwoPg, auxLdoThreePg, terminationLdoPg,
         sharedSourcePg, loadSwitchB1Pg} <= v;
        repeat (2) @(posedge core_clk);
        g = {auxLdoTwoPg, loadSwitchAPg, stepDownPg, ctlPin[4], ctlPin[3], ctlPin[1], ctlPin[0],
             terminationLdoPg, sharedSourcePg, loadSwitchB1Pg, auxLdoThreePg, ctlPin[2], ctlPin[5]};
        p = {ctlPin[2], ctlPin[5]};
        e = {&(p | mask[2][5:4]), &(p | mask[2][3:2]), &(p | mask[2][7:6]),
             &(g | {mask[0], mask[1], mask[2][1:0]})};
        chk({4'h0, other, third}, {4'h0, e});
    endtask
    // unmapped offset: acknowledged, dropped
    task automatic wr_reg(input int k, input logic [7:0] v);
        host.wr(pg_mask_pkg::DEV_ADDR, ofsTab[k], v, nak);
        chk({7'h00, nak}, 8'h00);
        if (k < 3)
            mask[k] = v;
    endtask
    task automatic rd_chk(input int k);
        host.rd(ofsTab[k], rdv, rdv2);
        chk(rdv, (k < 3) ? mask[k] : pg_mask_pkg::UNMAPPED);
        chk(rdv2, (k < 2) ? mask[k + 1] : pg_mask_pkg::UNMAPPED);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (90000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        seed = 44;
        failures = 0;
        nTests = 0;
        {stepDownPg, ctlPin, loadSwitchAPg, auxLdoTwoPg, auxLdoThreePg, terminationLdoPg,
         sharedSourcePg, loadSwitchB1Pg} = '1;
        mask = '{pg_mask_pkg::RST_RAILS, pg_mask_pkg::RST_PINS, pg_mask_pkg::RST_CTL};
        ofsTab = '{pg_mask_pkg::OFS_RAILS, pg_mask_pkg::OFS_PINS, pg_mask_pkg::OFS_CTL, 8'hAD};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int k = 0; k < 4; k++)
            rd_chk(k);
        host.wr(pg_mask_pkg::DEV_ADDR ^ 7'h01, pg_mask_pkg::OFS_RAILS, 8'h00, nak);
        chk({7'h00, nak}, 8'h01);
        rd_chk(0);
        // walking bad source, all included then all masked
        for (int m = 0; m < 2; m++)
        begin
            for (int k = 0; k < 3; k++)
                wr_reg(k, (m == 1) ? 8'hFF : 8'h00);
            for (int j = 0; j < 18; j++)
                set_src(~(18'h1 << j));
        end
        set_src(18'h0);
        for (int i = 0; i < 24; i++)
        begin
            wr_reg(i % 4, 8'($random(seed)));
            rd_chk(i % 4);
            repeat (6)
                set_src(18'($random(seed) | $random(seed) | $random(seed)));
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
